// *** design/light_sensor_map.svh ***
// Purpose: Offsets, field positions and reset values of the sensor status register bank.
// Assumes: Registers are 16 bits wide and addressed by an 8-bit I2C register pointer.
// Notes: Definitions only.
`ifndef LIGHT_SENSOR_MAP_SVH
`define LIGHT_SENSOR_MAP_SVH

`define LSIS_OFS_MAIN_CFG 8'h0a
`define LSIS_OFS_INT_CFG 8'h0b
`define LSIS_OFS_FLAGS 8'h0c
`define LSIS_OFS_PART_ID 8'h11

`define LSIS_INT_CFG_RESET 16'h8011
`define LSIS_INT_CFG_FIXED_VALUE 9'h080
`define LSIS_SRC_HI 6
`define LSIS_SRC_LO 5
`define LSIS_DIR_BIT 4
`define LSIS_EOC_HI 3
`define LSIS_EOC_LO 2
`define LSIS_BURST_BIT 0

`define LSIS_EOC_ALERT 2'h0
`define LSIS_EOC_PER_CHANNEL 2'h1
`define LSIS_EOC_ALL_CHANNELS 2'h3

`define LSIS_EXP_HI 15
`define LSIS_EXP_LO 12
`define LSIS_MANT_HI 11
`define LSIS_MANT_LO 0

`define LSIS_I2C_ADDR_DEFAULT 7'h44
`define LSIS_PART_CODE_LOW_DEFAULT 2'h1
`define LSIS_PART_CODE_HIGH_DEFAULT 12'h5a5

`endif

// *** design/lsis_pkg.sv ***
// Purpose: Types shared by the sensor status register bank.
// Assumes: Nothing beyond the map header.
// Notes: States of the I2C target engine.
package lsis_pkg;
    typedef enum logic [2:0] {
        LSIS_IDLE,
        LSIS_ADDR,
        LSIS_ACK,
        LSIS_PTR,
        LSIS_WDAT,
        LSIS_RD,
        LSIS_RACK
    } lsis_state_t;
endpackage

// *** design/lsis_regs.sv ***
// Purpose: Interrupt configuration, event flag and identification registers behind an I2C target.
// Assumes: Pins are synchronous to clock_in; the conversion engine reports each channel result as a pulse.
// Notes: Open-drain pins are split into input, output and output enable.
// Behaviour
// - Source field picks compared channel, resets zero
// - Direction bit: clear input, set output
// - End-of-conversion field selects alert or pulse mode
// - Burst bit advances read pointer after reads
// - Overflow sets read-only overload indicator
// - End of conversion sets ready indicator
// - Main config read or nonzero write clears ready
// - Consecutive below-low results set low indicator
// - Fault code needs 1, 2, 4, 8 results
// - Thresholds are exponent and mantissa values
// - Polarity bit selects active low or high
`timescale 1ns/1ps
`include "light_sensor_map.svh"

module lsis_regs
    import lsis_pkg::*;
#(
    parameter logic [6:0] I2C_ADDR = `LSIS_I2C_ADDR_DEFAULT,
    // Identification values below are arbitrary.
    parameter logic [1:0] PART_CODE_LOW = `LSIS_PART_CODE_LOW_DEFAULT,
    parameter logic [11:0] PART_CODE_HIGH = `LSIS_PART_CODE_HIGH_DEFAULT
)
(
    input wire logic clock_in,              // System clock, 10 MHz.
    input wire logic rst_in,                // Asynchronous reset, active high.
    input wire logic scl_in,                // I2C clock level.
    input wire logic sda_in,                // I2C data level.
    output logic sda_out,                   // I2C data drive value, always low.
    output logic sda_oe_out,                // High while pulling data low.
    input wire logic int_in,                // Interrupt pin level.
    output logic int_out,                   // Interrupt pin drive value, always low.
    output logic int_oe_out,                // High while pulling interrupt pin low.
    output logic trigger_out,               // Interrupt pin level captured when it is an input.
    input wire logic irq_pin_polarity_in,   // Zero active low, one active high.
    input wire logic [1:0] fault_count_in,  // Consecutive result code.
    input wire logic [15:0] thr_low_in,     // Low threshold, exponent and mantissa.
    input wire logic [15:0] thr_high_in,    // High threshold, exponent and mantissa.
    input wire logic ch_done_in,            // Pulse: one channel result valid.
    input wire logic [1:0] ch_idx_in,       // Channel of the result.
    input wire logic [15:0] ch_result_in,   // Result, exponent and mantissa.
    input wire logic ch_overflow_in,        // Result overflowed the range.
    input wire logic conv_done_in,          // Pulse: conversion of all channels complete.
    output logic [1:0] compare_source_select_out, // Channel fed to threshold compare.
    output logic [3:0] event_flags_out      // Overload, ready, high, low.
);

    // ------------------------------------------------------------
    // Registers and pin sampling
    // ------------------------------------------------------------
    logic [15:0] int_cfg_r;
    logic overrange_indicator_r;
    logic ready_r;
    logic flag_h_r;
    logic flag_l_r;
    logic scl_q_r;
    logic sda_q_r;
    lsis_state_t state_r;
    logic [3:0] bitcnt_r;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic [7:0] ptr_r;
    logic [7:0] hi_r;
    logic byte_sel_r;
    logic rw_r;
    logic ptr_got_r;
    logic [3:0] low_cnt_r;
    logic [3:0] high_cnt_r;
    logic pulse_r;

    wire scl_rise = scl_in & ~scl_q_r;
    wire scl_fall = ~scl_in & scl_q_r;
    wire start_det = scl_in & scl_q_r & sda_q_r & ~sda_in;
    wire stop_det = scl_in & scl_q_r & ~sda_q_r & sda_in;
    wire byte_done = (bitcnt_r == 4'h8);

    function automatic logic [15:0] read_word(input logic [7:0] addr);
        case (addr)
            `LSIS_OFS_INT_CFG: read_word = int_cfg_r;
            `LSIS_OFS_FLAGS: read_word = {12'h000, overrange_indicator_r, ready_r, flag_h_r, flag_l_r};
            `LSIS_OFS_PART_ID: read_word = {2'h0, PART_CODE_LOW, PART_CODE_HIGH};
            default: read_word = 16'h0000;
        endcase
    endfunction

    // Threshold format is a mantissa scaled by two to the exponent.
    function automatic logic [26:0] level(input logic [15:0] v);
        level = {15'h0000, v[`LSIS_MANT_HI:`LSIS_MANT_LO]} << v[`LSIS_EXP_HI:`LSIS_EXP_LO];
    endfunction

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end
        else
        begin
            scl_q_r <= scl_in;
            sda_q_r <= sda_in;
        end
    end

    // ------------------------------------------------------------
    // I2C target engine
    // ------------------------------------------------------------
    wire write_strobe = (state_r == LSIS_WDAT) && scl_fall && byte_done && byte_sel_r;
    wire [15:0] write_word = {hi_r, shift_r};
    wire read_strobe = (state_r == LSIS_RD) && scl_fall && byte_done && byte_sel_r;
    wire [15:0] cur_word = read_word(ptr_r);

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_r <= LSIS_IDLE;
            bitcnt_r <= 4'h0;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            ptr_r <= 8'h00;
            hi_r <= 8'h00;
            byte_sel_r <= 1'b0;
            rw_r <= 1'b0;
            ptr_got_r <= 1'b0;
            sda_oe_out <= 1'b0;
        end
        else if (start_det)
        begin
            state_r <= LSIS_ADDR;
            bitcnt_r <= 4'h0;
            ptr_got_r <= 1'b0;
            sda_oe_out <= 1'b0;
        end
        else if (stop_det)
        begin
            state_r <= LSIS_IDLE;
            sda_oe_out <= 1'b0;
        end
        else if (scl_rise)
        begin
            if (state_r == LSIS_ADDR || state_r == LSIS_PTR || state_r == LSIS_WDAT || state_r == LSIS_RD)
            begin
                shift_r <= {shift_r[6:0], sda_in};
                bitcnt_r <= bitcnt_r + 4'h1;
            end
            if (state_r == LSIS_RACK)
            begin
                rw_r <= ~sda_in;
            end
        end
        else if (scl_fall)
        begin
            case (state_r)
                LSIS_ADDR:
                begin
                    if (byte_done)
                    begin
                        bitcnt_r <= 4'h0;
                        if (shift_r[7:1] == I2C_ADDR)
                        begin
                            rw_r <= shift_r[0];
                            byte_sel_r <= 1'b0;
                            sda_oe_out <= 1'b1;
                            state_r <= LSIS_ACK;
                        end
                        else
                        begin
                            state_r <= LSIS_IDLE;
                        end
                    end
                end
                LSIS_ACK:
                begin
                    bitcnt_r <= 4'h0;
                    if (rw_r)
                    begin
                        tx_r <= {cur_word[14:8], 1'b0};
                        sda_oe_out <= ~cur_word[15];
                        state_r <= LSIS_RD;
                    end
                    else
                    begin
                        sda_oe_out <= 1'b0;
                        state_r <= ptr_got_r ? LSIS_WDAT : LSIS_PTR;
                    end
                end
                LSIS_PTR:
                begin
                    if (byte_done)
                    begin
                        ptr_r <= shift_r;
                        ptr_got_r <= 1'b1;
                        byte_sel_r <= 1'b0;
                        sda_oe_out <= 1'b1;
                        state_r <= LSIS_ACK;
                    end
                end
                LSIS_WDAT:
                begin
                    if (byte_done)
                    begin
                        hi_r <= shift_r;
                        byte_sel_r <= ~byte_sel_r;
                        sda_oe_out <= 1'b1;
                        state_r <= LSIS_ACK;
                    end
                end
                LSIS_RD:
                begin
                    if (byte_done)
                    begin
                        sda_oe_out <= 1'b0;
                        state_r <= LSIS_RACK;
                    end
                    else
                    begin
                        sda_oe_out <= ~tx_r[7];
                        tx_r <= {tx_r[6:0], 1'b0};
                    end
                end
                LSIS_RACK:
                begin
                    bitcnt_r <= 4'h0;
                    if (!rw_r)
                    begin
                        state_r <= LSIS_IDLE;
                    end
                    else if (!byte_sel_r)
                    begin
                        byte_sel_r <= 1'b1;
                        tx_r <= {cur_word[6:0], 1'b0};
                        sda_oe_out <= ~cur_word[7];
                        state_r <= LSIS_RD;
                    end
                    else
                    begin
                        // With the burst bit set, the pointer stepped at the end of the low byte, so the next word is current here.
                        byte_sel_r <= 1'b0;
                        tx_r <= {cur_word[14:8], 1'b0};
                        sda_oe_out <= ~cur_word[15];
                        state_r <= LSIS_RD;
                    end
                end
                default: state_r <= LSIS_IDLE;
            endcase
        end
        if (read_strobe && int_cfg_r[`LSIS_BURST_BIT] && !start_det && !stop_det)
        begin
            ptr_r <= ptr_r + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Configuration word
    // ------------------------------------------------------------
    // Stored as written; the host keeps the fixed and reserved fields.
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            int_cfg_r <= `LSIS_INT_CFG_RESET;
        end
        else if (write_strobe && ptr_r == `LSIS_OFS_INT_CFG)
        begin
            int_cfg_r <= write_word;
        end
    end

    // ------------------------------------------------------------
    // Threshold compare and event flags
    // ------------------------------------------------------------
    wire sel_hit = ch_done_in && (ch_idx_in == int_cfg_r[`LSIS_SRC_HI:`LSIS_SRC_LO]);
    wire [3:0] need = 4'h1 << fault_count_in;
    wire below = level(ch_result_in) < level(thr_low_in);
    wire above = level(ch_result_in) > level(thr_high_in);
    wire flags_read = read_strobe && ptr_r == `LSIS_OFS_FLAGS;
    wire ready_clr = (read_strobe && ptr_r == `LSIS_OFS_MAIN_CFG)
        || (write_strobe && ptr_r == `LSIS_OFS_MAIN_CFG && write_word != 16'h0000);
    // Saturate at or above the need, so a lowered fault code never lets the count wrap.
    wire [3:0] low_next = (low_cnt_r >= need) ? need : low_cnt_r + 4'h1;
    wire [3:0] high_next = (high_cnt_r >= need) ? need : high_cnt_r + 4'h1;

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            low_cnt_r <= 4'h0;
            high_cnt_r <= 4'h0;
        end
        else if (sel_hit)
        begin
            low_cnt_r <= below ? low_next : 4'h0;
            high_cnt_r <= above ? high_next : 4'h0;
        end
    end

    // Set wins over a clear in the same cycle.
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            overrange_indicator_r <= 1'b0;
            ready_r <= 1'b0;
            flag_h_r <= 1'b0;
            flag_l_r <= 1'b0;
        end
        else
        begin
            overrange_indicator_r <= (ch_done_in && ch_overflow_in) | (overrange_indicator_r & ~flags_read);
            ready_r <= conv_done_in | (ready_r & ~ready_clr);
            flag_l_r <= (sel_hit && below && low_next >= need) | (flag_l_r & ~flags_read);
            flag_h_r <= (sel_hit && above && high_next >= need) | (flag_h_r & ~flags_read);
        end
    end

    // ------------------------------------------------------------
    // Interrupt pin
    // ------------------------------------------------------------
    wire [1:0] eoc_mode = int_cfg_r[`LSIS_EOC_HI:`LSIS_EOC_LO];
    wire pin_active = (eoc_mode == `LSIS_EOC_ALERT) ? (flag_h_r | flag_l_r) : pulse_r;

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pulse_r <= 1'b0;
        end
        else
        begin
            pulse_r <= (eoc_mode == `LSIS_EOC_PER_CHANNEL && ch_done_in)
                || (eoc_mode == `LSIS_EOC_ALL_CHANNELS && conv_done_in);
        end
    end

    // The pin is open drain, so an active-high level is shown by releasing it.
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            int_oe_out <= 1'b0;
            trigger_out <= 1'b0;
        end
        else
        begin
            int_oe_out <= int_cfg_r[`LSIS_DIR_BIT] && (pin_active ^ irq_pin_polarity_in);
            trigger_out <= int_cfg_r[`LSIS_DIR_BIT] ? 1'b0 : int_in;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sda_out <= 1'b0;
            int_out <= 1'b0;
            compare_source_select_out <= 2'h0;
            event_flags_out <= 4'h0;
        end
        else
        begin
            sda_out <= 1'b0;
            int_out <= 1'b0;
            compare_source_select_out <= int_cfg_r[`LSIS_SRC_HI:`LSIS_SRC_LO];
            event_flags_out <= {overrange_indicator_r, ready_r, flag_h_r, flag_l_r};
        end
    end

endmodule

// *** tb/lsis_i2c_host.sv ***
// Purpose: Bus host that reads and writes 16-bit words.
// Assumes: Pull-up on data; the host never stretches or waits on the clock.
// Notes: Seven bench clocks per bit.
`timescale 1ns/1ps
module lsis_i2c_host #(
    parameter logic [6:0] ADDR = 7'h44
)
(
    input wire logic clock_in,   // Bench clock.
    input wire logic sda_oe_in,  // Device pulls data low.
    output logic scl_out,        // Bus clock.
    output wire logic sda_out    // Resolved data line.
);
    logic drv = 1'b1;
    int nacks = 0;
    initial scl_out = 1'b1;
    // Wired-and: either party pulling low wins over the pull-up.
    assign sda_out = drv & ~sda_oe_in;
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
    endtask
    task automatic bit_io(input logic b, output logic r);
        drv <= b;
        tick(3);
        scl_out <= 1'b1;
        tick(3);
        r = sda_out;
        scl_out <= 1'b0;
        tick(1);
    endtask
    task automatic start();
        drv <= 1'b1;
        tick(1);
        scl_out <= 1'b1;
        tick(3);
        drv <= 1'b0;
        tick(3);
        scl_out <= 1'b0;
        tick(1);
    endtask
    task automatic stop();
        drv <= 1'b0;
        tick(2);
        scl_out <= 1'b1;
        tick(3);
        drv <= 1'b1;
        tick(3);
    endtask
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q);
        logic k;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(a, k);
        nacks += (a && k);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        logic [7:0] b;
        start();
        xfer({ADDR, 1'b0}, 1'b1, b);
        xfer(a, 1'b1, b);
        xfer(v[15:8], 1'b1, b);
        xfer(v[7:0], 1'b1, b);
        stop();
    endtask
    task automatic rd(input logic [7:0] a, input int n, output logic [31:0] w);
        logic [7:0] b;
        w = 32'h0;
        start();
        xfer({ADDR, 1'b0}, 1'b1, b);
        xfer(a, 1'b1, b);
        start();
        xfer({ADDR, 1'b1}, 1'b1, b);
        for (int i = 0; i < 2 * n; i++)
        begin
            xfer(8'hff, i == 2 * n - 1, b);
            w = {w[23:0], b};
        end
        // The closing not-acknowledge is the host's own, not a refusal.
        nacks--;
        stop();
    endtask
endmodule

// *** tb/lsis_regs_checker.sv ***
// Purpose: Port assertions for the sensor status register bank.
// Assumes: Thresholds and channel select hold steady around each result pulse.
// Notes: Event flags show two clocks after the event.
`timescale 1ns/1ps
module lsis_regs_checker (
    input wire logic clock_in,                  // Clock.
    input wire logic rst_in,                    // Reset.
    input wire logic int_out,                   // Pin drive value.
    input wire logic int_oe_out,                // Pin pull-down.
    input wire logic trigger_out,               // Captured pin level.
    input wire logic [1:0] fault_count_in,      // Fault code.
    input wire logic [15:0] thr_low_in,         // Low threshold.
    input wire logic [15:0] thr_high_in,        // High threshold.
    input wire logic ch_done_in,                // Result pulse.
    input wire logic [1:0] ch_idx_in,           // Result channel.
    input wire logic [15:0] ch_result_in,       // Result.
    input wire logic ch_overflow_in,            // Overflow.
    input wire logic conv_done_in,              // Conversion pulse.
    input wire logic [1:0] compare_source_select_out, // Compared channel.
    input wire logic [3:0] event_flags_out      // Flags.
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);
    pin_low_a: assert property (int_out == 1'b0) else $error("pin drive not low");
    pin_dir_a: assert property (int_oe_out |-> !trigger_out) else $error("pin both ways");
    ready_set_a: assert property (conv_done_in |-> ##2 event_flags_out[2]) else $error("ready late");
    ready_cause_a: assert property ($rose(event_flags_out[2]) |-> $past(conv_done_in, 2))
        else $error("ready without conversion");
    over_set_a: assert property (ch_done_in && ch_overflow_in |-> ##2 event_flags_out[3])
        else $error("overload late");
    over_cause_a: assert property ($rose(event_flags_out[3]) |-> $past(ch_overflow_in, 2))
        else $error("overload without overflow");
    low_set_a: assert property (ch_done_in && ch_idx_in == compare_source_select_out && fault_count_in == 2'h0
        && ch_result_in == 16'h0000 && thr_low_in[11:0] != 12'h000 |-> ##2 event_flags_out[0])
        else $error("low flag late");
    high_set_a: assert property (ch_done_in && ch_idx_in == compare_source_select_out && fault_count_in == 2'h0
        && ch_result_in == 16'hffff && thr_high_in == 16'h0000 |-> ##2 event_flags_out[1])
        else $error("high flag late");
    low_cause_a: assert property ($rose(event_flags_out[0]) |-> $past(ch_done_in, 2))
        else $error("low flag without result");
endmodule
bind lsis_regs lsis_regs_checker u_chk (.clock_in, .rst_in, .int_out, .int_oe_out, .trigger_out, .fault_count_in,
    .thr_low_in, .thr_high_in, .ch_done_in, .ch_idx_in, .ch_result_in, .ch_overflow_in, .conv_done_in,
    .compare_source_select_out, .event_flags_out);

// *** tb/tb_top.sv ***
// Purpose: Register and event tests of the sensor status bank.
// Assumes: Default bus address and part codes.
// Notes: Ends by close_out.
`timescale 1ns/1ps
`include "light_sensor_map.svh"
module tb_top;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic int_ext = 1'b1;
    logic irq_pin_polarity_in, ch_done_in, ch_overflow_in, conv_done_in;
    logic [1:0] fault_count_in, ch_idx_in;
    logic [15:0] thr_low_in, thr_high_in, ch_result_in;
    logic scl, sda_out, sda_oe_out, int_out, int_oe_out, trigger_out;
    wire logic sda;
    wire logic int_in = int_ext & ~int_oe_out;
    logic [1:0] compare_source_select_out;
    logic [3:0] event_flags_out;
    logic [31:0] w;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #50 clock_in = ~clock_in;
    lsis_regs u_dut (.clock_in, .rst_in, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe_out, .int_in, .int_out,
        .int_oe_out, .trigger_out, .irq_pin_polarity_in, .fault_count_in, .thr_low_in, .thr_high_in, .ch_done_in,
        .ch_idx_in, .ch_result_in, .ch_overflow_in, .conv_done_in, .compare_source_select_out, .event_flags_out);
    lsis_i2c_host u_host (.clock_in, .sda_oe_in(sda_oe_out), .scl_out(scl), .sda_out(sda));
    task automatic close_out();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pulse(input logic [1:0] i, input logic [15:0] r, input logic o);
        ch_idx_in <= i;
        ch_result_in <= r;
        ch_overflow_in <= o;
        ch_done_in <= 1'b1;
        u_host.tick(1);
        ch_done_in <= 1'b0;
        u_host.tick(3);
    endtask
    task automatic conv();
        conv_done_in <= 1'b1;
        u_host.tick(1);
        conv_done_in <= 1'b0;
        u_host.tick(3);
    endtask
    task automatic irq(input logic [15:0] cfg, input logic p, input logic cv, input logic [31:0] exp);
        logic [31:0] hits;
        hits = 0;
        u_host.wr(8'h0b, cfg);
        irq_pin_polarity_in <= p;
        u_host.tick(3);
        conv_done_in <= cv;
        ch_done_in <= !cv;
        ch_idx_in <= 2'h1;
        u_host.tick(1);
        conv_done_in <= 1'b0;
        ch_done_in <= 1'b0;
        repeat (6)
        begin
            @(posedge clock_in);
            hits += int_oe_out;
        end
        chk(hits, exp);
    endtask
    always @(posedge clock_in)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            fails++;
            close_out();
        end
    end
    initial
    begin
        @(posedge clock_in);
        irq_pin_polarity_in <= 1'b0;
        fault_count_in <= 2'h0;
        thr_low_in <= 16'h0100;
        thr_high_in <= 16'hbfff;
        ch_done_in <= 1'b0;
        ch_idx_in <= 2'h0;
        ch_result_in <= 16'h0000;
        ch_overflow_in <= 1'b0;
        conv_done_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        u_host.tick(2);
        // -----------------------------------------------------------
        // Register map
        // -----------------------------------------------------------
        u_host.rd(8'h0b, 2, w);
        chk(w, 32'h8011_0000);
        chk(compare_source_select_out, 32'h0);
        u_host.rd(8'h11, 1, w);
        chk(w, {18'h0, `LSIS_PART_CODE_LOW_DEFAULT, `LSIS_PART_CODE_HIGH_DEFAULT});
        u_host.rd(8'h05, 1, w);
        chk(w, 32'h0);
        u_host.wr(8'h0b, 16'h8040);
        u_host.rd(8'h0b, 2, w);
        chk(w, 32'h8040_8040);
        chk(compare_source_select_out, 32'h2);
        chk(trigger_out, 32'h1);
        int_ext <= 1'b0;
        u_host.tick(2);
        chk({int_oe_out, trigger_out}, 32'h0);
        chk({sda_out, int_out}, 32'h0);
        $display("test registers finished");
        // -----------------------------------------------------------
        // Flags
        // -----------------------------------------------------------
        for (int c = 0; c < 4; c++)
        begin
            fault_count_in <= c[1:0];
            pulse(2'h2, 16'h0200, 1'b0);
            pulse(2'h1, 16'h0000, 1'b0);
            repeat ((1 << c) - 1)
                pulse(2'h2, 16'h0000, 1'b0);
            chk(event_flags_out, 32'h0);
            pulse(2'h2, 16'h0000, 1'b0);
            chk(event_flags_out, 32'h1);
            u_host.rd(8'h0c, 1, w);
            chk(w, 32'h1);
        end
        thr_low_in <= 16'h1080;
        fault_count_in <= 2'h0;
        pulse(2'h2, 16'h00ff, 1'b0);
        chk(event_flags_out, 32'h1);
        thr_high_in <= 16'h0000;
        pulse(2'h2, 16'hffff, 1'b0);
        chk(event_flags_out, 32'h3);
        pulse(2'h3, 16'h0000, 1'b1);
        chk(event_flags_out, 32'hb);
        u_host.rd(8'h0c, 1, w);
        chk({w[27:0], event_flags_out}, 32'hb0);
        conv();
        chk(event_flags_out, 32'h4);
        u_host.rd(8'h0a, 1, w);
        chk(event_flags_out, 32'h0);
        conv();
        u_host.wr(8'h0a, 16'h0000);
        chk(event_flags_out, 32'h4);
        u_host.wr(8'h0a, 16'h0001);
        chk(event_flags_out, 32'h0);
        $display("test flags finished");
        // -----------------------------------------------------------
        // Interrupt pin
        // -----------------------------------------------------------
        int_ext <= 1'b1;
        irq(16'h801c, 1'b0, 1'b1, 32'h1);
        irq(16'h8014, 1'b0, 1'b0, 32'h1);
        irq(16'h8014, 1'b0, 1'b1, 32'h0);
        irq(16'h801c, 1'b0, 1'b0, 32'h0);
        irq(16'h801c, 1'b1, 1'b1, 32'h5);
        irq(16'h8010, 1'b0, 1'b0, 32'h0);
        pulse(2'h0, 16'hffff, 1'b0);
        chk(int_oe_out, 32'h1);
        u_host.rd(8'h0c, 1, w);
        chk(int_oe_out, 32'h0);
        $display("test pin finished");
        chk(u_host.nacks, 32'h0);
        close_out();
    end
endmodule
